// ==== srgt_top.sv ====
// Purpose: timing core of a two-gate synchronous rectifier controller
// Assumes: comparator flags arrive asynchronously; APB register access
// Notes: dead time is a software register in core cycles
//
// Chosen here: the address map and the APB interface to the registers.
`timescale 1ns/10ps
`include "srgt_cfg.svh"
module srgt_top #(
  parameter int unsigned FB_PERIOD_CYC = `SRGT_FB_PERIOD_CYC
) (
  input wire logic i_clk, // 100 MHz core clock
  input wire logic i_rst_b, // sync reset, active low
  input wire logic [1:0] i_drain_sense_low, // drain below 2 V, per channel
  input wire logic i_pin_short_level, // program_resistor_pin below short level
  input wire logic i_pin_open_level, // program_resistor_pin above open level
  input wire logic i_fast_switching_mode, // pin level selects fast mode
  input wire logic i_feedback_rise, // feedback current rose over 20 percent
  input wire logic i_feedback_short, // supply minus feedback below 0.3 V
  input wire logic i_supply_ov, // supply above 27 V
  input wire logic i_temp_hot, // die above 140 C
  input wire logic i_temp_cool, // die below 120 C
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB enable
  input wire logic i_pwrite, // APB write
  input wire srgt_pkg::srgt_addr_t i_paddr, // APB byte address
  input wire logic [31:0] i_pwdata, // APB write data
  output logic [31:0] o_prdata, // APB read data
  output logic o_pready, // APB ready
  output logic o_pslverr, // APB error on unmapped address
  output logic [1:0] o_gate, // rectifier gate commands
  output logic o_green, // green mode active
  output logic o_disabled // any protection holding gates off
);
  import srgt_pkg::*;

  function automatic logic [2:0] srgt_sel(input srgt_addr_t a);
    case (a)
      `SRGT_OFF_CTRL: srgt_sel = 3'h0;
      `SRGT_OFF_DEAD: srgt_sel = 3'h1;
      `SRGT_OFF_STAT: srgt_sel = 3'h2;
      `SRGT_OFF_DUR0: srgt_sel = 3'h3;
      `SRGT_OFF_DUR1: srgt_sel = 3'h4;
      default: srgt_sel = 3'h7;
    endcase
  endfunction

  // Synchronised and filtered flags
  logic short_lvl, short_held, open_lvl, open_held;
  logic fast_lvl, fbr_lvl, fbs_lvl, fbs_held, ov_lvl, hot_lvl, cool_lvl;
  logic [1:0] sense_lvl, sense_db;

  srgt_persist #(.CYC(`SRGT_PIN_FAULT_CYC + 1)) u_short (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_async(i_pin_short_level),
    .o_level(short_lvl), .o_held(short_held));
  srgt_persist #(.CYC(`SRGT_PIN_FAULT_CYC + 1)) u_open (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_async(i_pin_open_level),
    .o_level(open_lvl), .o_held(open_held));
  srgt_persist #(.CYC(1)) u_fast (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_async(i_fast_switching_mode),
    .o_level(fast_lvl), .o_held());
  srgt_persist #(.CYC(1)) u_fbr (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_async(i_feedback_rise),
    .o_level(fbr_lvl), .o_held());
  srgt_persist #(.CYC(`SRGT_SCP_DB_CYC)) u_fbs (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_async(i_feedback_short),
    .o_level(fbs_lvl), .o_held(fbs_held));
  srgt_persist #(.CYC(1)) u_ov (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_async(i_supply_ov),
    .o_level(ov_lvl), .o_held());
  srgt_persist #(.CYC(1)) u_hot (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_async(i_temp_hot),
    .o_level(hot_lvl), .o_held());
  srgt_persist #(.CYC(1)) u_cool (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_async(i_temp_cool),
    .o_level(cool_lvl), .o_held());

  // Registers
  logic ctrl_en_q;
  srgt_dur_t dead_q;
  logic [31:0] prdata_q;
  logic wr_en;
  logic clr_req;
  assign wr_en = i_psel & i_penable & i_pwrite;
  assign clr_req = wr_en & (srgt_sel(i_paddr) == 3'h0) & i_pwdata[`SRGT_CTRL_CLR_BIT];

  // Protection state
  logic pin_fault_q, scp_q, ot_q, fbr_q;
  logic [13:0] fb_tmr_q;
  logic [1:0] green_q;
  logic green_any, allowed;
  srgt_dur_t dur_q [2];

  assign green_any = |green_q;
  // any of these holds both gates low
  assign allowed = ctrl_en_q & ~pin_fault_q & ~scp_q & ~ov_lvl & ~ot_q & ~green_any;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      pin_fault_q <= 1'b0;
    end else if (short_held | open_held) begin
      pin_fault_q <= 1'b1;
    end else if (clr_req) begin
      pin_fault_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      scp_q <= 1'b0;
    end else if (fbs_held) begin
      scp_q <= 1'b1;
    end else if (clr_req) begin
      scp_q <= 1'b0;
    end
  end

  // Hysteresis: set above 140 C, released only once below 120 C
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ot_q <= 1'b0;
    end else if (hot_lvl) begin
      ot_q <= 1'b1;
    end else if (cool_lvl) begin
      ot_q <= 1'b0;
    end
  end

  // Each new rise report restarts the shrink period
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      fbr_q <= 1'b0;
      fb_tmr_q <= 14'h0000;
    end else begin
      fbr_q <= fbr_lvl;
      if (fbr_lvl & ~fbr_q) begin
        fb_tmr_q <= 14'(FB_PERIOD_CYC);
      end else if (fb_tmr_q != 14'h0000) begin
        fb_tmr_q <= fb_tmr_q - 14'h0001;
      end
    end
  end

  srgt_dur_t green_thr;
  assign green_thr = fast_lvl ? 13'(`SRGT_GREEN_FAST_CYC) : 13'(`SRGT_GREEN_SLOW_CYC);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_ch
      srgt_persist #(.CYC(`SRGT_DB_CYC)) u_sense (
        .i_clk(i_clk), .i_rst_b(i_rst_b), .i_async(i_drain_sense_low[g]),
        .o_level(sense_lvl[g]), .o_held(sense_db[g]));

      srgt_state_e st_q;
      logic sl, sl_q, fall, rise;
      srgt_dur_t lo_cnt_q, tgt_q, shrink, sum, tgt_d;
      logic [4:0] prop_q;
      logic [10:0] on_cnt_q;
      logic [3:0] win_q;
      logic [5:0] sd_q;
      logic [4:0] rhi_q;
      logic ring_arm_q, ring_pend_q, dt_pend_q;
      logic [11:0] hi_run_q;
      logic [2:0] srun_q, lrun_q;
      logic start, turn_off;

      assign sl = sense_lvl[g];
      assign fall = sl & ~sl_q;
      assign rise = ~sl & sl_q;
      assign start = (st_q == ST_PROP) & (prop_q == 5'(`SRGT_PROP_CYC - 1)) & sl;

      // Largest single shrink applies
      always_comb begin
        shrink = 13'h0000;
        if (dt_pend_q) begin
          shrink = 13'(`SRGT_SHRINK_DT_CYC);
        end
        if (ring_pend_q && shrink < 13'(`SRGT_SHRINK_RNG_CYC)) begin
          shrink = 13'(`SRGT_SHRINK_RNG_CYC);
        end
        if (fb_tmr_q != 14'h0000 && shrink < 13'(`SRGT_SHRINK_FB_CYC)) begin
          shrink = 13'(`SRGT_SHRINK_FB_CYC);
        end
        sum = dead_q + shrink;
        if (sum < dead_q) begin
          sum = 13'h1FFF;
        end
        tgt_d = (dur_q[g] > sum) ? dur_q[g] - sum : 13'h0000;
      end

      always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
          sl_q <= 1'b0;
        end else begin
          sl_q <= sl;
        end
      end

      // Conduction timer keeps running in green mode so exit can be seen
      always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
          lo_cnt_q <= 13'h0000;
          dur_q[g] <= 13'h0000;
        end else begin
          if (fall) begin
            lo_cnt_q <= 13'h0001;
          end else if (sl && lo_cnt_q != 13'h1FFF) begin
            lo_cnt_q <= lo_cnt_q + 13'h0001;
          end
          if (rise) begin
            dur_q[g] <= lo_cnt_q;
          end
        end
      end

      assign turn_off = (st_q == ST_ON) & (
        ({2'h0, on_cnt_q} + 13'h0001 >= tgt_q) |
        (on_cnt_q + 11'h001 >= 11'(`SRGT_MAXON_CYC)) |
        (~sl & (on_cnt_q >= 11'(`SRGT_BLANK_CYC))) |
        ~allowed);

      always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
          st_q <= ST_WAIT_LOW;
          prop_q <= 5'h00;
          on_cnt_q <= 11'h000;
          tgt_q <= 13'h0000;
          o_gate[g] <= 1'b0;
        end else begin
          case (st_q)
            ST_WAIT_LOW: begin
              prop_q <= 5'h00;
              if (sense_db[g]) begin
                st_q <= ST_PROP;
              end
            end
            ST_PROP: begin
              prop_q <= prop_q + 5'h01;
              tgt_q <= tgt_d;
              if (!sl) begin
                st_q <= ST_WAIT_LOW;
              end else if (start) begin
                on_cnt_q <= 11'h000;
                if (allowed && tgt_d != 13'h0000) begin
                  st_q <= ST_ON;
                  o_gate[g] <= 1'b1;
                end else begin
                  st_q <= ST_COND;
                end
              end
            end
            ST_ON: begin
              on_cnt_q <= on_cnt_q + 11'h001;
              if (turn_off) begin
                o_gate[g] <= 1'b0;
                st_q <= sl ? ST_COND : ST_WAIT_LOW;
              end
            end
            ST_COND: begin
              if (!sl) begin
                st_q <= ST_WAIT_LOW;
              end
            end
            default: begin
              st_q <= ST_WAIT_LOW;
              o_gate[g] <= 1'b0;
            end
          endcase
        end
      end

      // Dead-time window opens at turn-off; pending shrink used by next gate
      always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
          win_q <= 4'h0;
          dt_pend_q <= 1'b0;
        end else begin
          if (turn_off) begin
            win_q <= 4'(`SRGT_DTWIN_CYC);
          end else if (win_q != 4'h0) begin
            win_q <= win_q - 4'h1;
          end
          if ((turn_off & ~sl) | (rise & (win_q != 4'h0))) begin
            dt_pend_q <= 1'b1;
          end else if (start) begin
            dt_pend_q <= 1'b0;
          end
        end
      end

      // Ringing: a brief low followed by a real high counts only once armed
      always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
          sd_q <= 6'h00;
          rhi_q <= 5'h00;
          ring_arm_q <= 1'b0;
          ring_pend_q <= 1'b0;
        end else begin
          if (fall) begin
            sd_q <= 6'h01;
          end else if (sl && sd_q != 6'h3F) begin
            sd_q <= sd_q + 6'h01;
          end
          if (sl) begin
            ring_arm_q <= 1'b0;
            rhi_q <= 5'h00;
          end else if (rise && sd_q < 6'(`SRGT_RNG_WIN_CYC)) begin
            ring_arm_q <= 1'b1;
            rhi_q <= 5'h01;
          end else if (ring_arm_q) begin
            rhi_q <= rhi_q + 5'h01;
            if (rhi_q >= 5'(`SRGT_RNG_HI_CYC)) begin
              ring_arm_q <= 1'b0;
            end
          end
          if (ring_arm_q && !sl && rhi_q >= 5'(`SRGT_RNG_HI_CYC)) begin
            ring_pend_q <= 1'b1;
          end else if (start) begin
            ring_pend_q <= 1'b0;
          end
        end
      end

      // Green entry by seven short cycles or a long drain high; exit by seven long cycles
      always_ff @(posedge i_clk) begin
        if (!i_rst_b) begin
          srun_q <= 3'h0;
          lrun_q <= 3'h0;
          hi_run_q <= 12'h000;
          green_q[g] <= 1'b0;
        end else begin
          if (sl) begin
            hi_run_q <= 12'h000;
          end else if (hi_run_q != 12'hFFF) begin
            hi_run_q <= hi_run_q + 12'h001;
          end
          if (rise) begin
            if (lo_cnt_q < green_thr) begin
              lrun_q <= 3'h0;
              srun_q <= (srun_q == 3'(`SRGT_GREEN_RUN)) ? srun_q : srun_q + 3'h1;
            end else begin
              srun_q <= 3'h0;
              lrun_q <= (lrun_q == 3'(`SRGT_GREEN_RUN)) ? lrun_q : lrun_q + 3'h1;
            end
          end
          if (hi_run_q > 12'(`SRGT_GREEN_DH_CYC)) begin
            green_q[g] <= 1'b1;
          end else if (rise && lo_cnt_q < green_thr
                       && srun_q == 3'(`SRGT_GREEN_RUN - 1)) begin
            green_q[g] <= 1'b1;
          end else if (rise && lo_cnt_q >= green_thr
                       && lrun_q == 3'(`SRGT_GREEN_RUN - 1)) begin
            green_q[g] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // APB: zero wait states, read data captured in the setup cycle
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ctrl_en_q <= `SRGT_CTRL_RST;
      dead_q <= `SRGT_DEAD_RST;
    end else if (wr_en) begin
      case (srgt_sel(i_paddr))
        3'h0: ctrl_en_q <= i_pwdata[`SRGT_CTRL_EN_BIT];
        3'h1: dead_q <= i_pwdata[12:0];
        default: ctrl_en_q <= ctrl_en_q;
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      prdata_q <= 32'h00000000;
    end else if (i_psel && !i_penable) begin
      case (srgt_sel(i_paddr))
        3'h0: prdata_q <= {31'h00000000, ctrl_en_q};
        3'h1: prdata_q <= {19'h00000, dead_q};
        3'h2: prdata_q <= {23'h000000, fb_tmr_q != 14'h0000, ot_q, ov_lvl, scp_q,
                           pin_fault_q, green_q, o_gate};
        3'h3: prdata_q <= {19'h00000, dur_q[0]};
        3'h4: prdata_q <= {19'h00000, dur_q[1]};
        default: prdata_q <= 32'h00000000;
      endcase
    end
  end

  assign o_prdata = prdata_q;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel & i_penable & (srgt_sel(i_paddr) == 3'h7);
  assign o_green = green_any;
  assign o_disabled = pin_fault_q | scp_q | ov_lvl | ot_q | ~ctrl_en_q;
endmodule

// ==== srgt_cfg.svh ====
// Purpose: constants of the rectifier gate timing core
// Assumes: 100 MHz core clock
// Notes: times in ns, cycle counts derived from them
`ifndef SRGT_CFG_SVH
`define SRGT_CFG_SVH

`define SRGT_CLK_MHZ 100
// Least times round up, windows and longest times round down
`define SRGT_UP(ns) (((ns) * `SRGT_CLK_MHZ + 999) / 1000)
`define SRGT_DN(ns) (((ns) * `SRGT_CLK_MHZ) / 1000)

`define SRGT_T_DB_NS 150
`define SRGT_T_PROP_NS 200
`define SRGT_T_DTWIN_NS 125
`define SRGT_T_SHRINK_DT_NS 1250
`define SRGT_T_SHRINK_FB_NS 1400
`define SRGT_T_FB_PERIOD_NS 90000
`define SRGT_T_RNG_WIN_NS 350
`define SRGT_T_RNG_HI_NS 150
`define SRGT_T_SHRINK_RNG_NS 1200
`define SRGT_T_GREEN_SLOW_NS 3750
`define SRGT_T_GREEN_FAST_NS 1900
`define SRGT_T_PIN_FAULT_NS 2000
`define SRGT_T_GREEN_DH_NS 24000
`define SRGT_T_SCP_DB_NS 16000
`define SRGT_T_MAXON_NS 10500
`define SRGT_T_BLANK_NS 300

`define SRGT_DB_CYC `SRGT_UP(`SRGT_T_DB_NS)
`define SRGT_PROP_CYC `SRGT_UP(`SRGT_T_PROP_NS)
`define SRGT_DTWIN_CYC `SRGT_DN(`SRGT_T_DTWIN_NS)
`define SRGT_SHRINK_DT_CYC `SRGT_UP(`SRGT_T_SHRINK_DT_NS)
`define SRGT_SHRINK_FB_CYC `SRGT_UP(`SRGT_T_SHRINK_FB_NS)
`define SRGT_FB_PERIOD_CYC `SRGT_UP(`SRGT_T_FB_PERIOD_NS)
`define SRGT_RNG_WIN_CYC `SRGT_DN(`SRGT_T_RNG_WIN_NS)
`define SRGT_RNG_HI_CYC `SRGT_UP(`SRGT_T_RNG_HI_NS)
`define SRGT_SHRINK_RNG_CYC `SRGT_UP(`SRGT_T_SHRINK_RNG_NS)
`define SRGT_GREEN_SLOW_CYC `SRGT_UP(`SRGT_T_GREEN_SLOW_NS)
`define SRGT_GREEN_FAST_CYC `SRGT_UP(`SRGT_T_GREEN_FAST_NS)
`define SRGT_PIN_FAULT_CYC `SRGT_UP(`SRGT_T_PIN_FAULT_NS)
`define SRGT_GREEN_DH_CYC `SRGT_UP(`SRGT_T_GREEN_DH_NS)
`define SRGT_SCP_DB_CYC `SRGT_UP(`SRGT_T_SCP_DB_NS)
`define SRGT_MAXON_CYC `SRGT_DN(`SRGT_T_MAXON_NS)
`define SRGT_BLANK_CYC `SRGT_UP(`SRGT_T_BLANK_NS)
`define SRGT_GREEN_RUN 7

// Register map, byte addresses
`define SRGT_OFF_CTRL 8'h00
`define SRGT_OFF_DEAD 8'h04
`define SRGT_OFF_STAT 8'h08
`define SRGT_OFF_DUR0 8'h0C
`define SRGT_OFF_DUR1 8'h10
`define SRGT_CTRL_EN_BIT 0
`define SRGT_CTRL_CLR_BIT 1
`define SRGT_CTRL_RST 1'h1
`define SRGT_DEAD_RST 13'h001E

`endif

// ==== srgt_pkg.sv ====
// Purpose: types of the rectifier gate timing core
// Assumes: nothing
// Notes: constants live in srgt_cfg.svh
package srgt_pkg;
  typedef enum logic [2:0] {
    ST_WAIT_LOW,
    ST_PROP,
    ST_ON,
    ST_COND
  } srgt_state_e;
  typedef logic [12:0] srgt_dur_t;
  typedef logic [7:0] srgt_addr_t;
endpackage

// ==== srgt_persist.sv ====
// Purpose: two-stage synchroniser with persistence counter
// Assumes: i_async comes from outside the clock domain
// Notes: o_held rises once the level has stood high CYC cycles
`timescale 1ns/10ps
module srgt_persist #(
  parameter int unsigned CYC = 1
) (
  input wire logic i_clk, // core clock
  input wire logic i_rst_b, // sync reset, active low
  input wire logic i_async, // raw comparator flag
  output logic o_level, // synchronised level
  output logic o_held // level stood CYC cycles
);
  logic meta_q;
  logic sync_q;
  logic [15:0] cnt_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= i_async;
      sync_q <= meta_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cnt_q <= 16'h0000;
    end else if (!sync_q) begin
      cnt_q <= 16'h0000;
    end else if (cnt_q != 16'hFFFF) begin
      cnt_q <= cnt_q + 16'h0001;
    end
  end

  assign o_level = sync_q;
  assign o_held = (cnt_q >= 16'(CYC));
endmodule

// ==== srgt_top_props.sv ====
// Purpose: port-level timing checks of the rectifier gate core
// Assumes: one clock domain, synchronous active-low reset
// Notes: run counters saturate; bounds leave room for the 2-stage sync
`timescale 1ns/10ps
module srgt_top_props (
  input wire logic i_clk, // core clock
  input wire logic i_rst_b, // sync reset, active low
  input wire logic [1:0] i_drain_sense_low, // drain sense per leg
  input wire logic i_pin_short_level, // pin short flag
  input wire logic i_pin_open_level, // pin open flag
  input wire logic i_feedback_short, // output short flag
  input wire logic i_supply_ov, // supply over-voltage flag
  input wire logic i_temp_hot, // hot flag
  input wire logic i_psel, // APB select
  input wire logic i_penable, // APB enable
  input wire logic o_pslverr, // APB error
  input wire logic [1:0] o_gate, // gate commands
  input wire logic o_green, // green mode
  input wire logic o_disabled // protection active
);
  logic [15:0] lo0_q, lo1_q, hi0_q, on0_q, pin_q, sc_q;
  function automatic logic [15:0] bump(input logic [15:0] c, input logic en);
    return !en ? 16'h0000 : (c == 16'hFFFF) ? c : c + 16'h0001;
  endfunction
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      {lo0_q, lo1_q, hi0_q, on0_q, pin_q, sc_q} <= '0;
    end else begin
      lo0_q <= bump(lo0_q, i_drain_sense_low[0]);
      lo1_q <= bump(lo1_q, i_drain_sense_low[1]);
      hi0_q <= bump(hi0_q, !i_drain_sense_low[0]);
      on0_q <= bump(on0_q, o_gate[0]);
      pin_q <= bump(pin_q, i_pin_short_level || i_pin_open_level);
      sc_q <= bump(sc_q, i_feedback_short);
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  a_turn_on_wait: assert property ($rose(o_gate[0]) |-> lo0_q >= 16'h0021)
    else $error("gate 0 rose too soon after drain low");
  a_leg_one_wait: assert property ($rose(o_gate[1]) |-> lo1_q >= 16'h0021)
    else $error("gate 1 rose too soon after drain low");
  a_on_time_cap: assert property (on0_q <= 16'h041C)
    else $error("gate 0 on beyond the longest on-time");
  a_ov_gates_off: assert property (i_supply_ov [*6] |-> o_disabled && o_gate == 2'b00)
    else $error("gates not forced off on over-voltage");
  a_hot_disable: assert property (i_temp_hot [*5] |-> o_disabled)
    else $error("no disable on over-temperature");
  a_pin_fault_trip: assert property (pin_q >= 16'h00D2 |-> o_disabled)
    else $error("pin fault not latched");
  a_short_trip: assert property (sc_q >= 16'h064A |-> o_disabled)
    else $error("output short not latched");
  a_burst_green: assert property (hi0_q >= 16'h096A |-> o_green)
    else $error("long drain high did not enter green");
  a_green_gates_off: assert property (o_green && $past(o_green) |-> o_gate == 2'b00)
    else $error("gate driven in green mode");
  a_protect_off: assert property (o_disabled && $past(o_disabled) |-> o_gate == 2'b00)
    else $error("gate driven while disabled");
  a_err_in_access: assert property (o_pslverr |-> i_psel && i_penable)
    else $error("slave error outside access phase");
endmodule
bind srgt_top srgt_top_props u_props (.i_clk, .i_rst_b, .i_drain_sense_low,
  .i_pin_short_level, .i_pin_open_level, .i_feedback_short, .i_supply_ov, .i_temp_hot,
  .i_psel, .i_penable, .o_pslverr, .o_gate, .o_green, .o_disabled);

// ==== srgt_conv_model.sv ====
// Purpose: resonant stage stand-in driving both drain-sense legs
// Assumes: lengths in core cycles; the legs conduct in turn
// Notes: widths logged per period, so a missing gate logs zero
`timescale 1ns/10ps
module srgt_conv_model (
  input wire logic i_clk, // core clock
  input wire logic i_run, // start new periods while high
  input wire logic [1:0] i_gate, // gate commands of the core
  output logic [1:0] o_drain_sense_low // drain below threshold, per leg
);
  int low_len = 600;
  int gap_len = 50;
  int plan[$];
  int lq[$];
  int w0[$];
  int w1[$];
  int c0, c1, len;
  bit busy = 1'b0;
  // Gate is read right after the edge, so counts match whole cycles
  task automatic step(input logic [1:0] lvl, input int n);
    repeat (n) begin
      o_drain_sense_low <= lvl;
      @(posedge i_clk);
      c0 += int'(i_gate[0] === 1'b1);
      c1 += int'(i_gate[1] === 1'b1);
    end
  endtask
  initial begin
    o_drain_sense_low = 2'b00;
    forever begin
      @(posedge i_clk);
      if (i_run === 1'b1) begin
        busy = 1'b1;
        len = (plan.size() > 0) ? plan.pop_front() : low_len;
        lq.push_back(len);
        c0 = 0;
        c1 = 0;
        step(2'b01, len);
        step(2'b00, gap_len);
        step(2'b10, len);
        step(2'b00, gap_len);
        w0.push_back(c0);
        w1.push_back(c1);
        busy = 1'b0;
      end
    end
  end
endmodule

// ==== sync_rectifier_gate_timing_test.sv ====
// Purpose: self-checking bench of the rectifier gate timing core
// Assumes: 100 MHz clock, APB master in the bench
// Notes: feedback shrink period shortened to keep the run brief
`timescale 1ns/10ps
`include "srgt_cfg.svh"
module sync_rectifier_gate_timing_test;
  import srgt_pkg::*;
  localparam int unsigned FBP = 3000;
  logic i_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [1:0] sense, gate;
  logic [2:0] flt = 3'h0;
  logic fast = 1'b0, fb_rise = 1'b0, ov = 1'b0, hot = 1'b0, cool = 1'b0, run = 1'b0;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pready, pslverr, green, disabled, er;
  srgt_addr_t paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  int err_count = 0, checks_done = 0, dead, l, th, found;
  srgt_top #(.FB_PERIOD_CYC(FBP)) DUT (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_drain_sense_low(sense), .i_pin_short_level(flt[0]), .i_pin_open_level(flt[1]),
    .i_fast_switching_mode(fast), .i_feedback_rise(fb_rise), .i_feedback_short(flt[2]),
    .i_supply_ov(ov), .i_temp_hot(hot), .i_temp_cool(cool), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_gate(gate),
    .o_green(green), .o_disabled(disabled));
  srgt_conv_model conv (.i_clk(i_clk), .i_run(run), .i_gate(gate),
    .o_drain_sense_low(sense));
  initial begin
    forever #5 i_clk = ~i_clk;
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp,
                       input int tol = 0);
    checks_done++;
    if (^seen === 1'bx || seen > exp + tol || seen + tol < exp) begin
      err_count++;
      $display("Error %s expected %0d seen %0d", nm, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic timeout(input string nm);
    err_count++;
    $display("Error wait for %s expected done seen timeout", nm);
    tally_and_finish();
  endtask
  // Entered just after a rising edge; one idle edge ends each transfer
  task automatic apb(input logic wr, input srgt_addr_t a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge i_clk);
    pen <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) timeout("pready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge i_clk);
  endtask
  task automatic wait_periods(input int n);
    int goal, k;
    goal = conv.lq.size() + n;
    k = 0;
    while (conv.lq.size() < goal && k < 4000 * n) begin
      @(posedge i_clk);
      k++;
    end
    if (k >= 4000 * n) timeout("period");
  endtask
  task automatic start_case(input int d);
    int k;
    k = 0;
    run <= 1'b0;
    @(posedge i_clk);
    while (conv.busy && k < 5000) begin
      @(posedge i_clk);
      k++;
    end
    i_rst_b <= 1'b0;
    repeat (6) @(posedge i_clk);
    i_rst_b <= 1'b1;
    conv.lq.delete();
    conv.w0.delete();
    conv.w1.delete();
    @(posedge i_clk);
    apb(1'b0, `SRGT_OFF_DEAD, 32'h0);
    check("dead time reset", rd, 32'h1E);
    apb(1'b0, `SRGT_OFF_CTRL, 32'h0);
    check("control reset", rd, 32'h1);
    dead = d;
    apb(1'b1, `SRGT_OFF_DEAD, d);
  endtask
  task automatic check_run();
    int e;
    check("first gate", conv.w0[0], 0);
    for (int j = 1; j < conv.w0.size(); j++) begin
      e = conv.lq[j - 1] - dead;
      if (e > `SRGT_MAXON_CYC) e = `SRGT_MAXON_CYC;
      check("width leg 0", conv.w0[j], e, 2);
      check("width leg 1", conv.w1[j], e, 2);
    end
  endtask
  initial begin
    void'($urandom(92));
    start_case(60 + $urandom % 31);
    apb(1'b0, 8'h14, 32'h0);
    check("unmapped read", rd, 32'h0);
    check("unmapped error", 32'(er), 32'h1);
    apb(1'b1, `SRGT_OFF_STAT, 32'hFFFF_FFFF);
    apb(1'b0, `SRGT_OFF_DEAD, 32'h0);
    check("dead time", rd, dead);
    l = 450;
    repeat (8) begin
      conv.plan.push_back(l);
      l += $urandom % 50;
    end
    repeat (2) conv.plan.push_back(2200);
    run <= 1'b1;
    wait_periods(11);
    run <= 1'b0;
    check_run();
    apb(1'b0, `SRGT_OFF_DUR0, 32'h0);
    check("duration leg 0", rd, 2200, 1);
    apb(1'b0, `SRGT_OFF_DUR1, 32'h0);
    check("duration leg 1", rd, 2200, 1);
    start_case(70);
    run <= 1'b1;
    wait_periods(3);
    repeat (650) @(posedge i_clk);
    fb_rise <= 1'b1;
    repeat (4) @(posedge i_clk);
    fb_rise <= 1'b0;
    apb(1'b0, `SRGT_OFF_STAT, 32'h0);
    check("feedback shrink flag", 32'(rd[8]), 32'h1);
    wait_periods(2);
    check("feedback shrunk width", conv.w0[$], 600 - 70 - 140, 2);
    wait_periods(2);
    check("width after shrink", conv.w0[$], 530, 2);
    start_case(60);
    fast <= 1'b1;
    repeat (19) conv.plan.push_back(300);
    run <= 1'b1;
    wait_periods(10);
    check("green in fast mode", 32'(green), 32'h0);
    check("fast mode width", conv.w0[$], 240, 2);
    fast <= 1'b0;
    wait_periods(9);
    check("green entered", 32'(green), 32'h1);
    check("no gate in green", conv.w0[$], 0);
    wait_periods(3);
    apb(1'b0, `SRGT_OFF_DUR0, 32'h0);
    check("duration in green", rd, 600, 1);
    check("green kept", 32'(green), 32'h1);
    wait_periods(8);
    check("green left", 32'(green), 32'h0);
    wait_periods(1);
    check("width after green", conv.w0[$], 540, 2);
    start_case(70);
    repeat (1500) @(posedge i_clk);
    check("green before burst", 32'(green), 32'h0);
    repeat (1100) @(posedge i_clk);
    check("burst green", 32'(green), 32'h1);
    start_case(70);
    run <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      th = (i == 2) ? `SRGT_SCP_DB_CYC : `SRGT_PIN_FAULT_CYC;
      flt[i] <= 1'b1;
      repeat (th - 30) @(posedge i_clk);
      check("fault too early", 32'(disabled), 32'h0);
      flt[i] <= 1'b0;
      repeat (5) @(posedge i_clk);
      flt[i] <= 1'b1;
      repeat (th + 30) @(posedge i_clk);
      flt[i] <= 1'b0;
      repeat (5) @(posedge i_clk);
      check("fault latched", 32'(disabled), 32'h1);
      apb(1'b1, `SRGT_OFF_CTRL, 32'h3);
      check("fault cleared", 32'(disabled), 32'h0);
    end
    ov <= 1'b1;
    repeat (10) @(posedge i_clk);
    check("over-voltage off", 32'(disabled), 32'h1);
    ov <= 1'b0;
    hot <= 1'b1;
    repeat (10) @(posedge i_clk);
    hot <= 1'b0;
    repeat (10) @(posedge i_clk);
    check("hot held", 32'(disabled), 32'h1);
    cool <= 1'b1;
    repeat (10) @(posedge i_clk);
    cool <= 1'b0;
    check("cool released", 32'(disabled), 32'h0);
    start_case(30);
    run <= 1'b1;
    wait_periods(6);
    found = 0;
    foreach (conv.w0[j]) found |= int'(conv.w0[j] >= 443 && conv.w0[j] <= 447);
    check("dead time shrink", found, 1);
    check("sense-high turn-off", conv.w0[1], 600 - 35, 2);
    apb(1'b1, `SRGT_OFF_DEAD, 32'h2BC);
    wait_periods(3);
    check("non-positive width", conv.w0[$], 0);
    tally_and_finish();
  end
endmodule
